// file: hdl/oecm_pkg.sv
// Constants, register map and field layout of the oscillator enable and clock monitor block.
// Function
// (R1) The external oscillator force bit (bit 7) keeps it running; clear, it runs on request.
// (R2) The high frequency oscillator force bit (bit 6) keeps it running; clear, only on request.
// (R3) The mid frequency oscillator force bit (bit 5) keeps it running; clear, only on request.
// (R4) The low frequency oscillator force bit (bit 4) keeps it running; clear, only on request.
// (R5) The secondary force bit (bit 3) keeps it running in its power mode; clear, on request.
// (R6) The converter RC force bit (bit 2) keeps it running; clear, a request may start it.
// (R7) The PLL select bit (bit 0) gives peripherals the external clock times four, else plain.
// (R8) The PLL select bit never changes the system clock source or its rate.
// (R9) A fault injection bit (5 sec, 3 pri, 1 sys) blocks that clock so its monitor times out.
// (R10) A monitor that loses its clock sets its failure flag: bit 4 sec, 2 pri, 0 system.
// (R11) A failure flag stays set after the clock recovers until software writes zero to it.
// (R12) Software uses fault injection only as a demonstration and returns each bit to zero.
// (R13) Both control registers reset to zero and unimplemented bits read as zero.
// (R14) The secondary power select bit picks high power when set and low power when clear.
// (R15) Each oscillator has a read-only ready flag, high only while it is enabled and ready.
// (R16) A monitor counts cycles without an edge of its clock and fails it at the timeout count.
// (R17) An unforced oscillator runs while any request for it is active and may stop when none is.
package oecm_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;

    // Printed register indices; the byte address is four times the index.
    localparam logic [15:0] IDX_OSC_CTRL3 = 16'h00AF;
    localparam logic [15:0] IDX_OSC_READY = 16'h00B2;
    localparam logic [15:0] IDX_FORCE_EN = 16'h00B3;
    localparam logic [15:0] IDX_MON_CTRL = 16'h0458;
    localparam logic [15:0] IDX_IRQ_STAT = 16'h0460;
    localparam logic [15:0] IDX_IRQ_MASK = 16'h0461;

    // Force enable register fields.
    localparam int FE_EXT = 7;
    localparam int FE_HF = 6;
    localparam int FE_MID = 5;
    localparam int FE_LOW = 4;
    localparam int FE_SEC = 3;
    localparam int FE_CRC = 2;
    localparam int FE_PLL = 0;
    localparam logic [7:0] FE_MASK = 8'hFD;

    // Control register 3 field.
    localparam int C3_SEC_PWR = 6;

    // Monitor control and status fields.
    localparam int MON_SEC_FI = 5;
    localparam int MON_SEC_FAIL = 4;
    localparam int MON_PRI_FI = 3;
    localparam int MON_PRI_FAIL = 2;
    localparam int MON_SYS_FI = 1;
    localparam int MON_SYS_FAIL = 0;

    // Oscillator indices on the run, request and stable vectors.
    localparam int OSC_EXT = 0;
    localparam int OSC_HF = 1;
    localparam int OSC_MID = 2;
    localparam int OSC_LOW = 3;
    localparam int OSC_SEC = 4;
    localparam int OSC_CRC = 5;
    localparam int NUM_OSC = 6;

    // Monitor indices; also the bit order of the interrupt registers.
    localparam int MON_SYS = 0;
    localparam int MON_PRI = 1;
    localparam int MON_SEC = 2;
    localparam int NUM_MON = 3;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int MON_TIMEOUT_CYC = 64;

    function automatic logic [ADDR_W-1:0] reg_addr(input logic [15:0] idx);
        reg_addr = {idx[ADDR_W-3:0], 2'b00};
    endfunction : reg_addr

endpackage : oecm_pkg

// file: hdl/oecm_clk_mon.sv
// Loss-of-clock monitor for one watched clock, counted in system clock cycles.
`timescale 1ns/100ps
module oecm_clk_mon
    import oecm_pkg::*;
#(
    parameter int TIMEOUT = MON_TIMEOUT_CYC
) (
    input wire logic sys_clk,   // reference clock
    input wire logic rst_sync_n, // synchronised reset
    input wire logic watch_in,  // watched clock, asynchronous
    input wire logic block,     // fault injection, blocks the watched clock
    output logic fail_pulse     // one cycle when the timeout is reached
);
    localparam int CW = $clog2(TIMEOUT + 1);
    localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT);

    // Refuse a timeout that the assertion window and counter cannot serve.
    if (TIMEOUT < 2 || TIMEOUT > 900) begin : g_bad_timeout
        $error("oecm_clk_mon: TIMEOUT out of range");
    end

    logic s1_r, s2_r, s3_r;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic fail_r, fail_nxt;
    logic edge_seen;

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            cnt_r <= '0;
            fail_r <= 1'b0;
        end else begin
            s1_r <= watch_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            cnt_r <= cnt_nxt;
            fail_r <= fail_nxt;
        end
    end

    always_comb begin
        edge_seen = (s2_r ^ s3_r) & ~block; // R9
        if (edge_seen) begin
            cnt_nxt = '0; // R16
        end else if (cnt_r != LIMIT) begin
            cnt_nxt = cnt_r + CW'(1); // R16
        end else begin
            cnt_nxt = cnt_r;
        end
        fail_nxt = (cnt_nxt == LIMIT) && (cnt_r != LIMIT); // R16
    end

    assign fail_pulse = fail_r;

    default clocking mon_cb @(posedge sys_clk); endclocking
    default disable iff (!rst_sync_n);

    edge_restarts_a: assert property (edge_seen |=> cnt_r == '0) // R16
        else $error("monitor count not restarted by an edge");
    inject_times_out_a: assert property ( // R9
        $rose(block) && cnt_r == '0 |-> ##[1:1000] fail_pulse)
        else $error("blocked clock did not time out");
    mon_fail_cv: cover property (fail_pulse);
endmodule : oecm_clk_mon

// file: hdl/oecm_top.sv
// Oscillator force enable, peripheral PLL select and fail-safe clock monitor with an APB slave.
`timescale 1ns/100ps
module oecm_top
    import oecm_pkg::*;
#(
    parameter int TIMEOUT = MON_TIMEOUT_CYC
) (
    input wire logic sys_clk,                // system clock, 250 MHz
    input wire logic rst_n,                  // asynchronous reset, active low
    input wire logic [ADDR_W-1:0] paddr,     // APB address
    input wire logic psel,                   // APB select
    input wire logic penable,                // APB enable
    input wire logic pwrite,                 // APB write
    input wire logic [DATA_W-1:0] pwdata,    // APB write data
    output logic [DATA_W-1:0] prdata,        // APB read data
    output logic pready,                     // APB ready
    output logic pslverr,                    // APB error on unmapped address
    input wire logic [NUM_OSC-1:0] periph_req, // peripheral oscillator requests
    input wire logic [NUM_OSC-1:0] osc_stable_in, // oscillator stable, asynchronous
    input wire logic pll_lock_in,            // PLL locked, asynchronous
    input wire logic sec_osc_clk_in,         // secondary oscillator to watch
    input wire logic prim_clk_in,            // primary oscillator to watch
    input wire logic sys_clk_mon_in,         // system clock source to watch
    output logic [NUM_OSC-1:0] osc_run,      // oscillator run enables
    output logic pll_run,                    // PLL enable
    output logic periph_ext_use_pll,         // peripheral external clock takes PLL output
    output logic sec_osc_high_power,         // secondary oscillator high power mode
    output logic irq                         // level interrupt
);
    // Refuse a timeout that the monitors cannot serve.
    if (TIMEOUT < 2 || TIMEOUT > 900) begin : g_bad_timeout
        $error("oecm_top: TIMEOUT out of range");
    end

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_CTRL3,
        SEL_READY,
        SEL_FORCE,
        SEL_MON,
        SEL_ISTAT,
        SEL_IMASK
    } oecm_sel_e;

    // Reset release through two flip-flops.
    logic rst_s1_r, rst_sync_n;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_sync_n <= rst_s1_r;
        end
    end

    // Oscillator status pins pass two flip-flops.
    logic [NUM_OSC:0] stab_s1_r, stab_s2_r;
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            stab_s1_r <= '0;
            stab_s2_r <= '0;
        end else begin
            stab_s1_r <= {pll_lock_in, osc_stable_in};
            stab_s2_r <= stab_s1_r;
        end
    end

    // APB decode.
    oecm_sel_e sel;
    logic setup_ph, access_ph, wr_en;
    always_comb begin
        if (paddr == reg_addr(IDX_OSC_CTRL3)) begin
            sel = SEL_CTRL3;
        end else if (paddr == reg_addr(IDX_OSC_READY)) begin
            sel = SEL_READY;
        end else if (paddr == reg_addr(IDX_FORCE_EN)) begin
            sel = SEL_FORCE;
        end else if (paddr == reg_addr(IDX_MON_CTRL)) begin
            sel = SEL_MON;
        end else if (paddr == reg_addr(IDX_IRQ_STAT)) begin
            sel = SEL_ISTAT;
        end else if (paddr == reg_addr(IDX_IRQ_MASK)) begin
            sel = SEL_IMASK;
        end else begin
            sel = SEL_NONE;
        end
        setup_ph = psel & ~penable;
        access_ph = psel & penable;
        wr_en = access_ph & pwrite & (sel != SEL_NONE);
    end

    assign pready = 1'b1;
    assign pslverr = access_ph & (sel == SEL_NONE);

    // Software state.
    logic [7:0] fe_r, fe_nxt;
    logic c3_pwr_r, c3_pwr_nxt;
    logic [NUM_MON-1:0] fi_r, fi_nxt;
    logic [NUM_MON-1:0] fail_r, fail_nxt;
    logic [NUM_MON-1:0] ist_r, ist_nxt;
    logic [NUM_MON-1:0] imask_r, imask_nxt;
    logic [NUM_MON-1:0] fail_pulse;
    logic [7:0] wbyte;

    always_comb begin
        wbyte = pwdata[7:0];
        fe_nxt = fe_r;
        c3_pwr_nxt = c3_pwr_r;
        fi_nxt = fi_r;
        fail_nxt = fail_r;
        ist_nxt = ist_r;
        imask_nxt = imask_r;
        if (wr_en && sel == SEL_FORCE) begin
            fe_nxt = wbyte & FE_MASK;
        end
        if (wr_en && sel == SEL_CTRL3) begin
            c3_pwr_nxt = wbyte[C3_SEC_PWR];
        end
        if (wr_en && sel == SEL_MON) begin
            fi_nxt[MON_SEC] = wbyte[MON_SEC_FI];
            fi_nxt[MON_PRI] = wbyte[MON_PRI_FI];
            fi_nxt[MON_SYS] = wbyte[MON_SYS_FI];
            fail_nxt[MON_SEC] = fail_r[MON_SEC] & wbyte[MON_SEC_FAIL]; // R11
            fail_nxt[MON_PRI] = fail_r[MON_PRI] & wbyte[MON_PRI_FAIL]; // R11
            fail_nxt[MON_SYS] = fail_r[MON_SYS] & wbyte[MON_SYS_FAIL]; // R11
        end
        if (wr_en && sel == SEL_ISTAT) begin
            ist_nxt = ist_r & ~wbyte[NUM_MON-1:0];
        end
        if (wr_en && sel == SEL_IMASK) begin
            imask_nxt = wbyte[NUM_MON-1:0];
        end
        // A detection in the same cycle as a clear wins.
        fail_nxt = fail_nxt | fail_pulse; // R10
        ist_nxt = ist_nxt | fail_pulse;
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fe_r <= REG_RESET; // R13
            c3_pwr_r <= 1'b0;
            fi_r <= '0; // R13
            fail_r <= '0; // R13
            ist_r <= '0;
            imask_r <= '0;
        end else begin
            fe_r <= fe_nxt;
            c3_pwr_r <= c3_pwr_nxt;
            fi_r <= fi_nxt;
            fail_r <= fail_nxt;
            ist_r <= ist_nxt;
            imask_r <= imask_nxt;
        end
    end

    // Oscillator run control, PLL routing and ready flags.
    logic [NUM_OSC-1:0] force_vec, run_nxt, run_r;
    logic pll_run_nxt, pll_run_r, pll_sel_r, pwr_r, irq_r, irq_nxt;
    logic [7:0] rdy_r, rdy_nxt;

    always_comb begin
        force_vec[OSC_EXT] = fe_r[FE_EXT]; // R1
        force_vec[OSC_HF] = fe_r[FE_HF]; // R2
        force_vec[OSC_MID] = fe_r[FE_MID]; // R3
        force_vec[OSC_LOW] = fe_r[FE_LOW]; // R4
        force_vec[OSC_SEC] = fe_r[FE_SEC]; // R5
        force_vec[OSC_CRC] = fe_r[FE_CRC]; // R6
        run_nxt = force_vec | periph_req; // R17
        // The PLL runs only for the peripheral path; the system clock never sees it.
        pll_run_nxt = fe_r[FE_PLL] & run_nxt[OSC_EXT]; // R8
        rdy_nxt = 8'h00;
        rdy_nxt[FE_EXT] = run_r[OSC_EXT] & stab_s2_r[OSC_EXT]; // R15
        rdy_nxt[FE_HF] = run_r[OSC_HF] & stab_s2_r[OSC_HF]; // R15
        rdy_nxt[FE_MID] = run_r[OSC_MID] & stab_s2_r[OSC_MID]; // R15
        rdy_nxt[FE_LOW] = run_r[OSC_LOW] & stab_s2_r[OSC_LOW]; // R15
        rdy_nxt[FE_SEC] = run_r[OSC_SEC] & stab_s2_r[OSC_SEC]; // R15
        rdy_nxt[FE_CRC] = run_r[OSC_CRC] & stab_s2_r[OSC_CRC]; // R15
        rdy_nxt[FE_PLL] = pll_run_r & stab_s2_r[NUM_OSC]; // R15
        irq_nxt = |(ist_nxt & imask_nxt);
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            run_r <= '0;
            pll_run_r <= 1'b0;
            pll_sel_r <= 1'b0;
            pwr_r <= 1'b0;
            rdy_r <= REG_RESET;
            irq_r <= 1'b0;
        end else begin
            run_r <= run_nxt;
            pll_run_r <= pll_run_nxt;
            pll_sel_r <= fe_nxt[FE_PLL]; // R7
            pwr_r <= c3_pwr_nxt; // R14
            rdy_r <= rdy_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign osc_run = run_r;
    assign pll_run = pll_run_r;
    assign periph_ext_use_pll = pll_sel_r;
    assign sec_osc_high_power = pwr_r;
    assign irq = irq_r;

    // Clock monitors.
    logic [NUM_MON-1:0] watch_vec;
    assign watch_vec = {sec_osc_clk_in, prim_clk_in, sys_clk_mon_in};

    for (genvar g = 0; g < NUM_MON; g++) begin : g_mon
        oecm_clk_mon #(
            .TIMEOUT(TIMEOUT)
        ) u_mon (
            .sys_clk(sys_clk),
            .rst_sync_n(rst_sync_n),
            .watch_in(watch_vec[g]),
            .block(fi_r[g]), // R9
            .fail_pulse(fail_pulse[g])
        );
    end

    // Read data is captured in the setup cycle and held through the access cycle.
    logic [7:0] rbyte;
    logic [DATA_W-1:0] prdata_r, prdata_nxt;

    always_comb begin
        rbyte = 8'h00; // R13
        case (sel)
            SEL_CTRL3: rbyte[C3_SEC_PWR] = c3_pwr_r;
            SEL_READY: rbyte = rdy_r;
            SEL_FORCE: rbyte = fe_r;
            SEL_MON: begin
                rbyte[MON_SEC_FI] = fi_r[MON_SEC];
                rbyte[MON_SEC_FAIL] = fail_r[MON_SEC];
                rbyte[MON_PRI_FI] = fi_r[MON_PRI];
                rbyte[MON_PRI_FAIL] = fail_r[MON_PRI];
                rbyte[MON_SYS_FI] = fi_r[MON_SYS];
                rbyte[MON_SYS_FAIL] = fail_r[MON_SYS];
            end
            SEL_ISTAT: rbyte[NUM_MON-1:0] = ist_r;
            SEL_IMASK: rbyte[NUM_MON-1:0] = imask_r;
            default: rbyte = 8'h00;
        endcase
        prdata_nxt = prdata_r;
        if (setup_ph) begin
            prdata_nxt = {24'h00_0000, rbyte};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            prdata_r <= '0;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

    assign prdata = prdata_r;

    default clocking top_cb @(posedge sys_clk); endclocking
    default disable iff (!rst_sync_n);

    ext_force_run_a: assert property (fe_r[FE_EXT] |=> osc_run[OSC_EXT]) // R1
        else $error("forced external oscillator not running");
    hf_force_run_a: assert property (fe_r[FE_HF] |=> osc_run[OSC_HF]) // R2
        else $error("forced high frequency oscillator not running");
    mid_force_run_a: assert property (fe_r[FE_MID] |=> osc_run[OSC_MID]) // R3
        else $error("forced mid frequency oscillator not running");
    low_force_run_a: assert property (fe_r[FE_LOW] |=> osc_run[OSC_LOW]) // R4
        else $error("forced low frequency oscillator not running");
    sec_force_run_a: assert property (fe_r[FE_SEC] |=> osc_run[OSC_SEC]) // R5
        else $error("forced secondary oscillator not running");
    crc_req_run_a: assert property ( // R6
        !fe_r[FE_CRC] && periph_req[OSC_CRC] |=> osc_run[OSC_CRC])
        else $error("requested converter oscillator not running");
    idle_osc_stops_a: assert property ( // R17
        fe_r[FE_HF:FE_LOW] == 3'b000 && periph_req[OSC_LOW:OSC_HF] == 3'b000
        |=> osc_run[OSC_LOW:OSC_HF] == 3'b000)
        else $error("unrequested oscillator kept running");
    pll_select_write_a: assert property ( // R7
        wr_en && sel == SEL_FORCE |=> ##1 periph_ext_use_pll == $past(pwdata[FE_PLL], 2))
        else $error("peripheral PLL select not applied");
    sec_power_write_a: assert property ( // R14
        wr_en && sel == SEL_CTRL3 |=> ##1 sec_osc_high_power == $past(pwdata[C3_SEC_PWR], 2))
        else $error("secondary power select not applied");
    fail_sets_flag_a: assert property (fail_pulse[MON_PRI] |=> fail_r[MON_PRI]) // R10
        else $error("primary failure not flagged");
    fail_sticky_a: assert property ( // R11
        fail_r[MON_SYS] && !(wr_en && sel == SEL_MON) |=> fail_r[MON_SYS])
        else $error("system clock failure flag cleared by itself");
    ready_needs_run_a: assert property (!osc_run[OSC_SEC] |=> !rdy_r[FE_SEC]) // R15
        else $error("ready flag set for stopped oscillator");
    reset_zero_a: assert property ( // R13
        $rose(rst_sync_n) |-> fe_r == 8'h00 && fi_r == '0 && fail_r == '0)
        else $error("control registers not zero after reset");
    irq_follows_a: assert property (fail_pulse[MON_SEC] && imask_r[MON_SEC] |=> irq)
        else $error("unmasked failure did not raise interrupt");

    force_on_cv: cover property (fe_r[FE_EXT] && !periph_req[OSC_EXT]);
    inject_fail_cv: cover property (fi_r[MON_SYS] ##[1:200] fail_r[MON_SYS]);
    flag_clear_cv: cover property (fail_r[MON_PRI] ##1 !fail_r[MON_PRI]);
    irq_cv: cover property ($rose(irq));
endmodule : oecm_top

// file: tb/oecm_partner.sv
// Behavioural oscillators and PLL that answer the run enables of the block.
`timescale 1ns/100ps
module oecm_partner
    import oecm_pkg::*;
(
    input wire logic sys_clk, // reference clock
    input wire logic [NUM_OSC-1:0] osc_run, // run enables
    input wire logic pll_run, // PLL enable
    output logic [NUM_OSC-1:0] osc_stable_in, // oscillator stable
    output logic pll_lock_in, // PLL locked
    output logic sec_osc_clk_in = 1'b0, // secondary clock
    output logic prim_clk_in = 1'b0, // primary clock
    output logic sys_clk_mon_in = 1'b0 // system clock source
);
    logic [NUM_OSC-1:0] warm1 = '0;
    logic [NUM_OSC-1:0] warm2 = '0;
    logic lock1 = 1'b0;

    initial osc_stable_in = '0;
    initial pll_lock_in = 1'b0;

    // An oscillator reports stable a few cycles after start and drops at once when stopped.
    always @(posedge sys_clk) begin
        warm1 <= osc_run;
        warm2 <= warm1;
        osc_stable_in <= warm2 & osc_run;
        lock1 <= pll_run;
        pll_lock_in <= lock1 & pll_run;
    end

    always #7 sec_osc_clk_in = ~sec_osc_clk_in;
    always #5 prim_clk_in = ~prim_clk_in;
    always #3.1 sys_clk_mon_in = ~sys_clk_mon_in;
endmodule : oecm_partner

// file: tb/tb_top.sv
// Self-checking bench of the oscillator enable and clock monitor block.
`timescale 1ns/100ps
module tb_top
    import oecm_pkg::*;
;
    localparam int TMO = 16;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [NUM_OSC-1:0] periph_req = '0;
    logic [NUM_OSC-1:0] osc_stable_in;
    logic pll_lock_in;
    logic sec_osc_clk_in;
    logic prim_clk_in;
    logic sys_clk_mon_in;
    logic [NUM_OSC-1:0] osc_run;
    logic pll_run;
    logic periph_ext_use_pll;
    logic sec_osc_high_power;
    logic irq;
    logic [DATA_W-1:0] rd;
    logic err;
    int failures = 0;
    int checked = 0;

    always #2 sys_clk = ~sys_clk;

    oecm_top #(.TIMEOUT(TMO)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .periph_req(periph_req),
        .osc_stable_in(osc_stable_in), .pll_lock_in(pll_lock_in),
        .sec_osc_clk_in(sec_osc_clk_in), .prim_clk_in(prim_clk_in),
        .sys_clk_mon_in(sys_clk_mon_in), .osc_run(osc_run),
        .pll_run(pll_run), .periph_ext_use_pll(periph_ext_use_pll),
        .sec_osc_high_power(sec_osc_high_power), .irq(irq));

    oecm_partner osc_u (.sys_clk(sys_clk), .osc_run(osc_run), .pll_run(pll_run),
        .osc_stable_in(osc_stable_in), .pll_lock_in(pll_lock_in),
        .sec_osc_clk_in(sec_osc_clk_in), .prim_clk_in(prim_clk_in),
        .sys_clk_mon_in(sys_clk_mon_in));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t %s got %h want %h", $time, what, seen, exp);
        end
    endtask : check

    // One APB transfer; data and error are taken at the edge that samples pready.
    task automatic apb(input logic [15:0] idx, input logic wr, input logic [7:0] wd);
        @(posedge sys_clk);
        paddr <= {idx[13:0], 2'b00};
        pwrite <= wr;
        pwdata <= {24'h00_0000, wd};
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic t_reset;
        apb(IDX_FORCE_EN, 1'b0, 8'h00);
        check(rd, 32'h0000_0000, "force reset");
        apb(IDX_MON_CTRL, 1'b0, 8'h00);
        check(rd, 32'h0000_0000, "monitor reset");
        apb(16'h0000, 1'b1, 8'hFF);
        check({31'h0000_0000, err}, 32'h0000_0001, "unmapped error");
        check({31'h0000_0000, pready}, 32'h0000_0001, "zero wait");
        apb(IDX_FORCE_EN, 1'b1, 8'hFF);
        apb(IDX_FORCE_EN, 1'b0, 8'h00);
        check(rd, 32'h0000_00FD, "unused bit");
    endtask : t_reset

    task automatic t_osc;
        for (int i = 0; i < NUM_OSC; i++) begin
            apb(IDX_FORCE_EN, 1'b1, 8'h80 >> i);
            settle(3);
            check(osc_run, 6'h01 << i, "forced on");
            apb(IDX_FORCE_EN, 1'b1, 8'h00);
            periph_req[i] <= 1'b1;
            settle(3);
            check(osc_run, 6'h01 << i, "requested");
            @(posedge sys_clk);
            periph_req <= '0;
            settle(3);
            check(osc_run, 6'h00, "released");
        end
    endtask : t_osc

    task automatic t_pll;
        apb(IDX_FORCE_EN, 1'b1, 8'h01);
        settle(3);
        check(periph_ext_use_pll, 1'b1, "pll select");
        check(pll_run, 1'b0, "pll idle");
        apb(IDX_FORCE_EN, 1'b1, 8'h81);
        settle(12);
        check(pll_run, 1'b1, "pll run");
        apb(IDX_OSC_READY, 1'b0, 8'h00);
        check(rd, 32'h0000_0081, "ready flags");
        apb(IDX_OSC_READY, 1'b1, 8'h00);
        apb(IDX_MON_CTRL, 1'b0, 8'h00);
        check(rd, 32'h0000_0000, "sys clock kept");
        apb(IDX_FORCE_EN, 1'b1, 8'h00);
        settle(3);
        check(periph_ext_use_pll, 1'b0, "pll deselect");
        apb(IDX_OSC_CTRL3, 1'b1, 8'h40);
        settle(3);
        check(sec_osc_high_power, 1'b1, "high power");
        apb(IDX_OSC_CTRL3, 1'b1, 8'h00);
        settle(3);
        check(sec_osc_high_power, 1'b0, "low power");
    endtask : t_pll

    task automatic t_mon;
        for (int j = 0; j < NUM_MON; j++) begin
            apb(IDX_IRQ_MASK, 1'b1, (j == 1) ? 8'h00 : 8'h07);
            apb(IDX_MON_CTRL, 1'b1, 8'h02 << (2 * j));
            settle(TMO + 12);
            apb(IDX_MON_CTRL, 1'b0, 8'h00);
            check(rd, 32'h0000_0003 << (2 * j), "fail flag");
            check(irq, j != 1, "irq level");
            apb(IDX_MON_CTRL, 1'b1, 8'h01 << (2 * j));
            settle(TMO + 12);
            apb(IDX_MON_CTRL, 1'b0, 8'h00);
            check(rd, 32'h0000_0001 << (2 * j), "flag sticky");
            apb(IDX_MON_CTRL, 1'b1, 8'h00);
            apb(IDX_MON_CTRL, 1'b0, 8'h00);
            check(rd, 32'h0000_0000, "flag cleared");
            apb(IDX_IRQ_STAT, 1'b0, 8'h00);
            check(rd, 32'h0000_0001 << j, "irq status");
            apb(IDX_IRQ_STAT, 1'b1, 8'h01 << j);
            settle(3);
            check(irq, 1'b0, "irq cleared");
        end
    endtask : t_mon

    task automatic close_out;
        if (failures == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_reset();
        t_osc();
        t_pll();
        t_mon();
        close_out();
    end

    initial begin
        #100000;
        failures++;
        close_out();
    end
endmodule : tb_top
